// [logic/adcsr_top.sv]
`include "adcsr_cfg.svh"
// Behaviour
// R1 - sclk high at select fall: next 8 falling edges load din into config
// R2 - host reads all old result bits before any bits of a newer result
// R3 - short readout keeps unread bits; next readout outputs only leftovers; daisy modes reload the result at every conversion end
// R4 - select rise in chip-select modes starts conversion, output floats
// R5 - a started conversion always completes regardless of the select line
// R6 - no-busy cs mode: select low through conversion shows msb at end
// R7 - no-busy cs mode: low select shows msb, shift, float after 18 edges
// R8 - busy cs mode: conversion end drives output low, then acquisition
// R9 - busy cs mode: msb first on edges, float after 19th edge or rise
// R10 - host raises each select before the minimum conversion time
// R11 - host reads shared bus by lowering one select and clocking bits
// R12 - no-busy daisy mode: conversion end shows msb, rest held in register
// R13 - daisy mode: low select, each falling edge shifts and loads din; in daisy busy mode the first edge only drops the busy bit
// R14 - host gives 18 falling edges per chained converter
// R15 - config bits 7:6 pick readout mode: cs, cs busy, daisy, daisy busy
// R16 - host waits the maximum conversion time in no-busy modes
// R17 - host gives 18 edges per converter plus one in daisy busy mode
// R18 - host waits 50ns after busy indication before daisy readout
// R19 - edges with select high and no config write leave data untouched
module adcsr_top import adcsr_pkg::*; #(
    parameter int RES_BITS = `ADCSR_RES_BITS,
    parameter int CONV_CYC = `ADCSR_CONV_CYC,
    parameter int PTR_BITS = `ADCSR_PTR_BITS
) (
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic SCLK,
    input wire logic CONVERT_SELECT_LINE,
    input wire logic DIN,
    input wire logic [RES_BITS-1:0] SAMPLE_DATA,
    output logic DOUT_O,
    output logic DOUT_OE,
    output logic [`ADCSR_CFG_BITS-1:0] CFG_BYTE,
    output logic CONVERTING
);
    localparam int DEPTH = 1 << PTR_BITS;
    localparam int CW = $clog2(CONV_CYC + 1) < 4 ? 4 : $clog2(CONV_CYC + 1);
    localparam int LW = $clog2(RES_BITS + 1);

    function automatic logic [PTR_BITS:0] bin2gray(logic [PTR_BITS:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PTR_BITS:0] gray2bin(logic [PTR_BITS:0] g);
        logic [PTR_BITS:0] b;
        b = '0;
        b[PTR_BITS] = g[PTR_BITS];
        for (int i = PTR_BITS - 1; i >= 0; i--) begin
            b[i] = g[i] ^ b[i+1];
        end
        return b;
    endfunction

    function automatic adcsr_mode_t mode_of(logic [`ADCSR_CFG_BITS-1:0] c);
        return c[`ADCSR_MODE_HI:`ADCSR_MODE_LO]; // R15
    endfunction

    logic rst_s1_q, rst_n_q;
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // link side: only counts falling edges and records din per edge;
    // the serial clock may stop between frames, so nothing else lives here
    logic [PTR_BITS:0] lbin_q, lgray_q, lbin_nx;
    logic din_mem [DEPTH];
    assign lbin_nx = lbin_q + 1'b1;
    always_ff @(negedge SCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lbin_q <= '0;
            lgray_q <= '0;
        end else begin
            lbin_q <= lbin_nx;
            lgray_q <= bin2gray(lbin_nx);
        end
    end
    always_ff @(negedge SCLK) begin
        din_mem[lbin_q[PTR_BITS-1:0]] <= DIN;
    end

    logic cs_s1_q, cs_s2_q, cs_d_q, sclk_s1_q, sclk_s2_q;
    logic [PTR_BITS:0] gray_s1_q, gray_s2_q, rd_q;
    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_d_q <= 1'b1;
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            gray_s1_q <= '0;
            gray_s2_q <= '0;
        end else begin
            cs_s1_q <= CONVERT_SELECT_LINE;
            cs_s2_q <= cs_s1_q;
            cs_d_q <= cs_s2_q;
            sclk_s1_q <= SCLK;
            sclk_s2_q <= sclk_s1_q;
            gray_s1_q <= lgray_q;
            gray_s2_q <= gray_s1_q;
        end
    end

    logic edge_v, cs_low, cs_rise, cs_fall, din_bit;
    assign edge_v = rd_q != gray2bin(gray_s2_q);
    assign din_bit = din_mem[rd_q[PTR_BITS-1:0]];
    assign cs_low = !cs_s2_q;
    assign cs_rise = cs_s2_q && !cs_d_q;
    assign cs_fall = !cs_s2_q && cs_d_q;

    // one edge consumed per cycle; the core clock outruns the link clock
    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rd_q <= '0;
        end else if (edge_v) begin
            rd_q <= rd_q + 1'b1;
        end
    end

    adcsr_state_e st_q;
    logic [CW-1:0] cnt_q;
    logic [RES_BITS-1:0] sr_q;
    logic [LW-1:0] left_q;
    logic busy_q, oe_q, dout_q, done, daisy, busy_md, load;
    logic [`ADCSR_CFG_BITS-1:0] cfg_q, cfg_sh_q;
    adcsr_mode_t mode;
    // a select on a call result is not portable, so decode into a net
    assign mode = mode_of(cfg_q);
    assign daisy = mode[`ADCSR_MODE_DAISY_BIT];
    assign busy_md = mode[`ADCSR_MODE_BUSY_BIT];
    assign done = st_q == ST_CONV && cnt_q == CW'(CONV_CYC - 1);
    assign load = left_q == '0 || daisy;

    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q <= ST_ACQ;
            cnt_q <= '0;
            sr_q <= '0;
            left_q <= '0;
            busy_q <= 1'b0;
            oe_q <= 1'b0;
            dout_q <= 1'b0;
            cfg_q <= `ADCSR_CFG_RESET;
            cfg_sh_q <= '0;
        end else begin
            case (st_q)
                ST_CONV: begin
                    // select line is ignored until the count ends
                    if (done) begin // R5
                        st_q <= ST_ACQ;
                        cnt_q <= '0;
                        if (load) begin // R3
                            sr_q <= SAMPLE_DATA;
                            left_q <= LW'(RES_BITS);
                        end
                        busy_q <= busy_md; // R8
                        if (busy_md) begin
                            dout_q <= 1'b0; // R8
                            oe_q <= 1'b1;
                        end else begin
                            dout_q <= load ? SAMPLE_DATA[RES_BITS-1]
                                           : sr_q[RES_BITS-1]; // R6 R12
                            oe_q <= daisy || cs_low; // R6 R12
                        end
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_CFG: begin
                    if (cs_rise) begin
                        st_q <= ST_ACQ;
                        cnt_q <= '0;
                    end else if (edge_v) begin // R1
                        cfg_sh_q <= {cfg_sh_q[`ADCSR_CFG_BITS-2:0], din_bit};
                        if (cnt_q == CW'(`ADCSR_CFG_BITS - 1)) begin
                            cfg_q <= {cfg_sh_q[`ADCSR_CFG_BITS-2:0], din_bit};
                            st_q <= ST_ACQ;
                            cnt_q <= '0;
                        end else begin
                            cnt_q <= cnt_q + 1'b1;
                        end
                    end
                end
                default: begin
                    if (cs_rise) begin
                        st_q <= ST_CONV; // R4
                        cnt_q <= '0;
                        if (!daisy) begin
                            oe_q <= 1'b0; // R4 R7 R9
                        end
                    end else if (cs_fall && sclk_s2_q) begin
                        st_q <= ST_CFG; // R1
                        cnt_q <= '0;
                        if (!daisy) begin
                            oe_q <= 1'b0;
                        end
                    end else if (cs_low && edge_v && oe_q) begin // R19
                        if (busy_q) begin
                            busy_q <= 1'b0; // R9
                            dout_q <= sr_q[RES_BITS-1];
                        end else if (daisy) begin
                            sr_q <= {sr_q[RES_BITS-2:0], din_bit}; // R13
                            dout_q <= sr_q[RES_BITS-2];
                            left_q <= (left_q == '0) ? '0 : left_q - 1'b1;
                        end else if (left_q != '0) begin
                            sr_q <= {sr_q[RES_BITS-2:0], 1'b0}; // R7 R9
                            dout_q <= sr_q[RES_BITS-2];
                            left_q <= left_q - 1'b1;
                            if (left_q == LW'(1)) begin
                                oe_q <= 1'b0; // R7 R9
                            end
                        end
                    end else if (cs_low && !oe_q && !daisy &&
                                 left_q != '0) begin
                        oe_q <= 1'b1; // R7
                        dout_q <= busy_q ? 1'b0 : sr_q[RES_BITS-1];
                    end
                end
            endcase
        end
    end

    logic conv_q;
    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            conv_q <= 1'b0;
        end else begin
            conv_q <= st_q == ST_CONV;
        end
    end

    assign DOUT_O = dout_q;
    assign DOUT_OE = oe_q;
    assign CFG_BYTE = cfg_q;
    assign CONVERTING = conv_q;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!rst_n_q);

    rise_floats_a: assert property ( // R4
        st_q == ST_ACQ && cs_rise && !daisy |=> !oe_q && st_q == ST_CONV)
        else $error("select rise did not start conversion and float");
    conv_holds_a: assert property ( // R5
        st_q == ST_CONV && !done |=> st_q == ST_CONV)
        else $error("conversion ended early");
    cs_msb_end_a: assert property ( // R6
        done && mode_of(cfg_q) == 2'b00 && cs_low && load
        |=> oe_q && dout_q == $past(SAMPLE_DATA[RES_BITS-1]))
        else $error("msb not shown at end of conversion");
    cs_last_edge_a: assert property ( // R7
        st_q == ST_ACQ && !cs_rise && !(cs_fall && sclk_s2_q) && cs_low &&
        edge_v && oe_q && !busy_q && !daisy && left_q == LW'(1)
        |=> !oe_q ##1 !oe_q)
        else $error("output not floated after last bit");
    busy_low_a: assert property ( // R8
        done && mode_of(cfg_q) == 2'b01 |=> oe_q && !dout_q && busy_q)
        else $error("busy indication missing");
    busy_drop_a: assert property ( // R9
        st_q == ST_ACQ && !cs_rise && !(cs_fall && sclk_s2_q) && cs_low &&
        edge_v && oe_q && busy_q
        |=> !busy_q && dout_q == $past(sr_q[RES_BITS-1]))
        else $error("busy bit not replaced by msb");
    daisy_msb_a: assert property ( // R12
        done && mode_of(cfg_q) == 2'b10
        |=> oe_q && dout_q == $past(SAMPLE_DATA[RES_BITS-1])
            && sr_q == $past(SAMPLE_DATA))
        else $error("daisy result not presented");
    daisy_shift_a: assert property ( // R13
        st_q == ST_ACQ && !cs_rise && !(cs_fall && sclk_s2_q) && cs_low &&
        edge_v && oe_q && !busy_q && daisy
        |=> sr_q == {$past(sr_q[RES_BITS-2:0]), $past(din_bit)})
        else $error("daisy shift wrong");
    leftover_keep_a: assert property ( // R3
        done && left_q != '0 && !daisy |=> $stable(sr_q) && $stable(left_q))
        else $error("unread bits overwritten");
    idle_edges_a: assert property ( // R19
        st_q == ST_ACQ && !cs_low && !cs_rise |=> $stable(sr_q))
        else $error("data changed with select high");
    cfg_load_a: assert property ( // R1
        st_q == ST_CFG && !cs_rise && edge_v &&
        cnt_q == CW'(`ADCSR_CFG_BITS - 1)
        |=> st_q == ST_ACQ &&
            cfg_q == {$past(cfg_sh_q[`ADCSR_CFG_BITS-2:0]), $past(din_bit)})
        else $error("config byte not loaded after 8 edges");
endmodule

// [logic/adcsr_cfg.svh]
`ifndef ADCSR_CFG_SVH
`define ADCSR_CFG_SVH
`define ADCSR_RES_BITS 18
`define ADCSR_CFG_BITS 8
`define ADCSR_CFG_RESET 8'h00
`define ADCSR_MODE_HI 7
`define ADCSR_MODE_LO 6
`define ADCSR_MODE_BUSY_BIT 0
`define ADCSR_MODE_DAISY_BIT 1
`define ADCSR_CLK_MHZ 100
`define ADCSR_T_CONV_NS 1500
`define ADCSR_CONV_CYC ((`ADCSR_T_CONV_NS * `ADCSR_CLK_MHZ + 999) / 1000)
`define ADCSR_PTR_BITS 3
`endif

// [logic/adcsr_pkg.sv]
package adcsr_pkg;
    typedef enum logic [1:0] {ST_ACQ, ST_CONV, ST_CFG} adcsr_state_e;
    typedef logic [1:0] adcsr_mode_t;
endpackage

// [tb/adcsr_host.sv]
module adcsr_host (
    output logic sclk,
    output logic sel,
    output logic din
);
    timeunit 1ns;
    timeprecision 100ps;
    // clock idles low so that a select fall never reads as a config write
    initial begin
        sclk = 1'b0;
        sel = 1'b1;
        din = 1'b0;
    end
    // 72 ns per edge: the core needs up to 30 ns to answer each fall
    task automatic fall(input logic d);
        din <= d;
        #6 sclk <= 1'b1;
        #6 sclk <= 1'b0;
        #60;
    endtask
    task automatic select(input logic v);
        sel <= v;
        #60;
    endtask
    // no-busy modes need the host to time the conversion out itself
    task automatic wait_conv();
        #300;
    endtask
    task automatic cfg(input logic [7:0] b);
        sclk <= 1'b1;
        #40 sel <= 1'b0;
        #40;
        for (int i = 7; i >= 0; i--) begin
            din <= b[i];
            #30 sclk <= 1'b0;
            #36 sclk <= (i != 0);
            #6;
        end
        #60 sel <= 1'b1;
        #60;
    endtask
endmodule

// [tb/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk;
    logic nrst;
    logic [17:0] sample;
    logic sclk;
    logic sel;
    logic din;
    logic dout_o;
    logic dout_oe;
    logic converting;
    logic [7:0] cfg_byte;
    // pull-up on the shared output line
    wire dout_w = dout_oe ? dout_o : 1'b1;
    int n_errors = 0;
    int n_compared = 0;
    adcsr_host host_u(.sclk(sclk), .sel(sel), .din(din));
    adcsr_top #(.CONV_CYC(8)) dut_u(.REF_CLK(ref_clk), .NRST(nrst),
        .SCLK(sclk), .CONVERT_SELECT_LINE(sel),
        .DIN(din), .SAMPLE_DATA(sample), .DOUT_O(dout_o),
        .DOUT_OE(dout_oe), .CFG_BYTE(cfg_byte), .CONVERTING(converting));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic end_of_test();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [17:0] d, u, input int hi, lo);
        for (int i = hi; i >= lo; i--) begin
            chk(18'(dout_w), 18'(d[i]));
            host_u.fall(u[i]);
        end
    endtask
    // a conversion started by the select rise is drained before each test
    task automatic setup(input logic [1:0] m, input logic [17:0] d);
        host_u.select(1'b1);
        host_u.wait_conv();
        host_u.cfg({m, 6'h00});
        host_u.wait_conv();
        chk(18'(cfg_byte), 18'({m, 6'h00}));
        host_u.select(1'b0);
        repeat (19) host_u.fall(1'b0);
        @(posedge ref_clk) sample <= d;
    endtask
    task automatic t_cs_low();
        setup(2'b00, 18'h2d5a3);
        host_u.select(1'b1);
        chk(18'(dout_oe), 18'h0);
        chk(18'(converting), 18'h1);
        host_u.select(1'b0);
        host_u.wait_conv();
        chk(18'(dout_oe), 18'h1);
        chk(18'(converting), 18'h0);
        rd(18'h2d5a3, 18'h0, 17, 0);
        chk(18'(dout_oe), 18'h0);
    endtask
    task automatic t_cs_high();
        setup(2'b00, 18'h1c3e5);
        host_u.select(1'b1);
        host_u.wait_conv();
        repeat (3) host_u.fall(1'b1);
        host_u.select(1'b0);
        rd(18'h1c3e5, 18'h0, 17, 0);
        chk(18'(dout_oe), 18'h0);
    endtask
    task automatic t_cs_busy();
        setup(2'b01, 18'h3a5c6);
        host_u.select(1'b1);
        host_u.wait_conv();
        chk({16'h0, dout_oe, dout_w}, 18'h2);
        host_u.select(1'b0);
        host_u.fall(1'b0);
        rd(18'h3a5c6, 18'h0, 17, 0);
        chk(18'(dout_oe), 18'h0);
    endtask
    task automatic t_daisy(input logic busy);
        setup({1'b1, busy}, 18'h25b7e);
        host_u.select(1'b1);
        host_u.wait_conv();
        chk(18'(dout_w), busy ? 18'h0 : 18'h1);
        host_u.select(1'b0);
        if (busy) host_u.fall(1'b0);
        rd(18'h25b7e, 18'h1a4c9, 17, 0);
        rd(18'h1a4c9, 18'h0, 17, 0);
    endtask
    // too few edges: the next readout carries only the leftovers
    task automatic t_partial();
        setup(2'b00, 18'h3c0a5);
        host_u.select(1'b1);
        host_u.wait_conv();
        host_u.select(1'b0);
        rd(18'h3c0a5, 18'h0, 17, 8);
        @(posedge ref_clk) sample <= 18'h0f0f0;
        host_u.select(1'b1);
        chk(18'(dout_oe), 18'h0);
        host_u.wait_conv();
        host_u.select(1'b0);
        rd(18'h3c0a5, 18'h0, 7, 0);
        chk(18'(dout_oe), 18'h0);
    endtask
    // reset in mid-run, with the link idle, must clear the mode byte
    task automatic t_reset();
        @(posedge ref_clk) nrst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk({7'h0, cfg_byte, dout_oe, dout_o, converting}, 18'h0);
        nrst <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk({7'h0, cfg_byte, dout_oe, dout_o, converting}, 18'h0);
    endtask
    initial begin
        #100000;
        n_errors++;
        end_of_test();
    end
    initial begin
        nrst <= 1'b0;
        sample <= 18'h00000;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk({7'h0, cfg_byte, dout_oe, dout_o, converting}, 18'h0);
        t_cs_low();
        t_cs_high();
        t_cs_busy();
        t_daisy(1'b0);
        t_daisy(1'b1);
        t_reset();
        t_partial();
        end_of_test();
    end
endmodule
